// ### tb_timer_counter_pwm16.sv
// Testbench for the timer: bus master tasks, fabric model and scenarios.
// Assumes tcp_pkg, tcp_timer, tcp_fabric and the checker compile first.
`timescale 1ns/1ps
`default_nettype none
module tb_timer_counter_pwm16;
    import tcp_pkg::*;
    logic        clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, cmp_out, exh, pwm_hi, pwm_lo, irq;
    logic        ext_clk, enable, timer_reset, capture, kill;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    int          bad_count, tests_run, cycles;
    tcp_timer dut_u
    (
        .CLK(clk), .RESETN(resetn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .EXT_CLK(ext_clk), .ENABLE(enable), .TIMER_RESET(timer_reset),
        .CAPTURE(capture), .KILL(kill), .CMP_OUT(cmp_out), .COUNT_EXHAUSTED(exh),
        .PWM_HI(pwm_hi), .PWM_LO(pwm_lo), .IRQ(irq)
    );
    tcp_fabric fab_u
    (
        .clk(clk), .ext_clk(ext_clk), .enable(enable), .timer_reset(timer_reset),
        .capture(capture), .kill(kill)
    );
    // ------------------------------------------------------------
    // Clock, hang guard and shared tasks
    // ------------------------------------------------------------
    always #50 clk = ~clk;
    // A stuck handshake would otherwise hang the run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            conclude();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Valid drops only at the edge where its own ready was seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge clk);
            awvalid <= awvalid && !awready;
            wvalid  <= wvalid && !wready;
        end
        while (!bvalid);
        bready <= 1'b0;
        check(bresp, er);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'b00);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge clk);
            arvalid <= arvalid && !arready;
        end
        while (!rvalid);
        rready <= 1'b0;
        check(rresp, er);
        check(rdata, exp);
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic sc_reset_values();
        rd(OFF_PERIOD, 32'hffff);
        rd(OFF_CMP, 32'h8000);
        rd(OFF_DEAD, 32'h0);
        wr(OFF_COUNT, 32'h1234, RESP_SLVERR);
        rd(OFF_COUNT, 32'hffff);
        rd(8'h28, 32'h0, RESP_SLVERR);
    endtask
    // Compare value 0 with less-than keeps the compare flag out of status
    task automatic sc_one_shot();
        wr(OFF_PERIOD, 32'h5);
        wr(OFF_CMP, 32'h0);
        wr(OFF_IEN, 32'h1);
        wr(OFF_CTRL, 32'h203);
        repeat (30) @(posedge clk);
        rd(OFF_COUNT, 32'h5);
        rd(OFF_STAT, 32'h1);
        check(irq, 1'b1);
        wr(OFF_IEN, 32'h0);
        repeat (2) @(posedge clk);
        check(irq, 1'b0);
        wr(OFF_CLR, 32'h7);
        wr(OFF_IEN, 32'h1);
        repeat (2) @(posedge clk);
        check(irq, 1'b0);
        rd(OFF_STAT, 32'h0);
    endtask
    // Held count 0x100 against 0x100 then 0x101; bit k is the result of function k % 5
    task automatic sc_gate_cmp();
        logic [9:0] tab = 10'b00011_01110;
        wr(OFF_PERIOD, 32'h100);
        wr(OFF_CTRL, 32'h305);
        repeat (4) @(posedge clk);
        rd(OFF_COUNT, 32'h100);
        for (int k = 0; k < 10; k++)
        begin
            wr(OFF_CMP, (k < 5) ? 32'h100 : 32'h101);
            wr(OFF_CTRL, 32'h105 | (32'(k % 5) << 3));
            repeat (4) @(posedge clk);
            check(cmp_out, tab[k]);
            check(exh, !tab[k]);
        end
        wr(OFF_CLR, 32'h7);
        fab_u.pulse(2, 3, 1);
        rd(OFF_CAPT, 32'h100);
        rd(OFF_STAT, 32'h4);
        fab_u.pulse(3, 10, 1);
        rd(OFF_COUNT, 32'hf6);
        wr(OFF_CTRL, 32'h10d);
        repeat (4) @(posedge clk);
        check(cmp_out, 1'b1);
        fab_u.set_line(4, 1'b1);
        repeat (6) @(posedge clk);
        check(cmp_out, 1'b0);
        fab_u.set_line(4, 1'b0);
    endtask
    task automatic sc_ext_source();
        wr(OFF_PERIOD, 32'hffff);
        wr(OFF_CTRL, 32'h281);
        rd(OFF_COUNT, 32'hffff);
        fab_u.pulse(0, 3, 3);
        rd(OFF_COUNT, 32'hfffc);
        fab_u.pulse(1, 3, 1);
        rd(OFF_COUNT, 32'hffff);
    endtask
    // Period 9 gives a ten-clock cycle, so 60 clocks hold six pulses
    task automatic sc_pwm_pair();
        int   n_exh = 0;
        logic seen_hi = 1'b0, seen_lo = 1'b0;
        wr(OFF_PERIOD, 32'h9);
        wr(OFF_CMP, 32'h5);
        wr(OFF_DEAD, 32'h2);
        wr(OFF_CTRL, 32'h201);
        repeat (20) @(posedge clk);
        repeat (60)
        begin
            @(posedge clk);
            n_exh += int'(exh);
            seen_hi |= pwm_hi;
            seen_lo |= pwm_lo;
        end
        check(n_exh, 6);
        check({seen_hi, seen_lo}, 2'b11);
    endtask
    initial
    begin
        clk = 1'b0;
        resetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        {bad_count, tests_run, cycles} = '0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        sc_reset_values();
        sc_one_shot();
        sc_gate_cmp();
        sc_ext_source();
        sc_pwm_pair();
        conclude();
    end
endmodule
bind tcp_timer tcp_timer_checker chk_u
(
    .CLK(CLK), .RESETN(RESETN), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .KILL(KILL),
    .CMP_OUT(CMP_OUT), .COUNT_EXHAUSTED(COUNT_EXHAUSTED), .PWM_HI(PWM_HI),
    .PWM_LO(PWM_LO), .IRQ(IRQ)
);
`default_nettype wire

// ### tcp_deadband.sv
// Complementary output pair with programmable dead time between edges.
// Assumes cnt_en pulses on CLK; dead time counts in count clocks.
`timescale 1ns/1ps
`default_nettype none
module tcp_deadband
#(
    parameter int DW = 8
)
(
    input  wire logic          clk,
    input  wire logic          resetn,
    input  wire logic          cnt_en,
    input  wire logic          pwm,
    input  wire logic [DW-1:0] dead,
    output logic               out_hi,
    output logic               out_lo
);
    logic [DW-1:0] gap_ff;
    logic          last_ff;
    // ------------------------------------------------------------------
    // Both outputs drop on any edge of pwm, and the new side waits out
    // the dead time so the pair is never active together
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            gap_ff  <= '0;
            last_ff <= 1'b0;
            out_hi  <= 1'b0;
            out_lo  <= 1'b0;
        end
        else if (pwm != last_ff)
        begin
            last_ff <= pwm;
            gap_ff  <= dead;
            out_hi  <= 1'b0;
            out_lo  <= 1'b0;
        end
        else if (gap_ff != '0)
        begin
            if (cnt_en)
                gap_ff <= gap_ff - 1'b1;
        end
        else
        begin
            out_hi <= last_ff;
            out_lo <= ~last_ff;
        end
    end
endmodule
`default_nettype wire

// ### tcp_edge.sv
// Two-flop synchroniser with rising-edge pulse, for routed pin inputs.
// Assumes input is asynchronous to CLK.
`timescale 1ns/1ps
`default_nettype none
module tcp_edge
(
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic din,
    output logic      level,
    output logic      rise
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    // ------------------------------------------------------------------
    // Synchroniser; first flop feeds only the second
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end
        else
        begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end
    assign level = s2_ff;
    assign rise  = s2_ff & ~s3_ff;
endmodule
`default_nettype wire

// ### tcp_fabric.sv
// Routing-fabric model driving the timer's routed control inputs.
// Assumes its tasks are called right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module tcp_fabric
(
    input  wire logic clk,
    output logic      ext_clk,
    output logic      enable,
    output logic      timer_reset,
    output logic      capture,
    output logic      kill
);
    // ------------------------------------------------------------
    // Lines idle low; the external count clock stands still when unused
    // ------------------------------------------------------------
    logic [4:0] line_ff = 5'h00;
    assign {kill, enable, capture, timer_reset, ext_clk} = line_ff;
    task automatic set_line(input int sel, input logic v);
        line_ff[sel] <= v;
    endtask
    // Pulses last several clocks so the two-flop sync cannot miss them
    task automatic pulse(input int sel, input int hi, input int n);
        repeat (n)
        begin
            set_line(sel, 1'b1);
            repeat (hi) @(posedge clk);
            set_line(sel, 1'b0);
            repeat (hi) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// ### tcp_pkg.sv
// Package for the 16-bit timer/counter/PWM block: register map, fields, resets.
// Assumes an AXI4-Lite slave with 32-bit data and one word per register.
package tcp_pkg;
    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_PERIOD  = 8'h04;
    localparam logic [7:0] OFF_CMP     = 8'h08;
    localparam logic [7:0] OFF_DEAD    = 8'h0c;
    localparam logic [7:0] OFF_COUNT   = 8'h10;
    localparam logic [7:0] OFF_CAPT    = 8'h14;
    localparam logic [7:0] OFF_STAT    = 8'h18;
    localparam logic [7:0] OFF_CLR     = 8'h1c;
    localparam logic [7:0] OFF_IEN     = 8'h20;
    localparam logic [7:0] OFF_CLKDIV  = 8'h24;
    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    localparam int CTRL_RUN    = 0;
    localparam int CTRL_MODE_L = 1;  // 2 bits: run mode
    localparam int CTRL_CMP_L  = 3;  // 3 bits: comparator function
    localparam int CTRL_CSEL_L = 6;  // 2 bits: count clock source
    localparam int CTRL_COMP   = 8;  // exhausted pin carries complement
    localparam int CTRL_START  = 9;  // write 1: reload and start
    // Status / interrupt bit positions
    localparam int ST_EXH  = 0;
    localparam int ST_CMP  = 1;
    localparam int ST_CAP  = 2;
    // Reset values
    localparam logic [15:0] RST_PERIOD = 16'hffff;
    localparam logic [15:0] RST_CMP    = 16'h8000;
    localparam logic [7:0]  RST_DEAD   = 8'h00;
    localparam logic [15:0] RST_CLKDIV = 16'h0000;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Run modes
    typedef enum logic [1:0] {
        MODE_FREE = 2'd0,
        MODE_ONCE = 2'd1,
        MODE_GATE = 2'd2
    } tcp_mode_t;
    // Comparator functions
    typedef enum logic [2:0] {
        CMP_LT = 3'd0,
        CMP_LE = 3'd1,
        CMP_EQ = 3'd2,
        CMP_GE = 3'd3,
        CMP_GT = 3'd4
    } tcp_cmp_t;
    // Count clock sources
    typedef enum logic [1:0] {
        CSRC_SYS  = 2'd0,
        CSRC_DIV  = 2'd1,
        CSRC_EXT  = 2'd2
    } tcp_csrc_t;
endpackage

// ### tcp_timer.sv
// Top of the 16-bit down-counting timer/counter/PWM with AXI4-Lite registers.
// Assumes routed inputs are asynchronous and pass a two-flop synchroniser.
`timescale 1ns/1ps
`default_nettype none
module tcp_timer
    import tcp_pkg::*;
#(
    parameter int CW = 16
)
(
    input  wire logic        CLK,
    input  wire logic        RESETN,
    // AXI4-Lite slave
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // Routed control inputs
    input  wire logic        EXT_CLK,
    input  wire logic        ENABLE,
    input  wire logic        TIMER_RESET,
    input  wire logic        CAPTURE,
    input  wire logic        KILL,
    // Routed outputs
    output logic             CMP_OUT,
    output logic             COUNT_EXHAUSTED,
    output logic             PWM_HI,
    output logic             PWM_LO,
    output logic             IRQ
);
    import tcp_pkg::*;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [31:0]   ctrl_ff;
    logic [CW-1:0] period_ff;
    logic [CW-1:0] cmp_ff;
    logic [7:0]    dead_ff;
    logic [15:0]   clkdiv_ff;
    logic [CW-1:0] count_ff;
    logic [CW-1:0] capt_ff;
    logic [2:0]    stat_ff;
    logic [2:0]    ien_ff;
    logic          start_ff;
    logic          stop_ff;
    logic [15:0]   div_cnt_ff;
    logic          div_tick_ff;

    // AXI handshake state
    logic          aw_ff;
    logic [7:0]    awaddr_ff;
    logic          w_ff;
    logic [31:0]   wdata_ff;
    logic [3:0]    wstrb_ff;

    // Synchronised inputs
    logic en_lvl;
    logic rst_rise;
    logic cap_rise;
    logic kill_lvl;
    logic ext_rise;

    tcp_edge u_en  (.clk(CLK), .resetn(RESETN), .din(ENABLE),      .level(en_lvl),  .rise());
    tcp_edge u_rst (.clk(CLK), .resetn(RESETN), .din(TIMER_RESET), .level(),        .rise(rst_rise));
    tcp_edge u_cap (.clk(CLK), .resetn(RESETN), .din(CAPTURE),     .level(),        .rise(cap_rise));
    tcp_edge u_kil (.clk(CLK), .resetn(RESETN), .din(KILL),        .level(kill_lvl), .rise());
    tcp_edge u_ext (.clk(CLK), .resetn(RESETN), .din(EXT_CLK),     .level(),        .rise(ext_rise));

    // ------------------------------------------------------------------
    // Field views
    // ------------------------------------------------------------------
    logic       run;
    tcp_mode_t  mode;
    tcp_cmp_t   cmp_sel;
    tcp_csrc_t  csel;
    assign run     = ctrl_ff[CTRL_RUN];
    assign mode    = tcp_mode_t'(ctrl_ff[CTRL_MODE_L +: 2]);
    assign cmp_sel = tcp_cmp_t'(ctrl_ff[CTRL_CMP_L +: 3]);
    assign csel    = tcp_csrc_t'(ctrl_ff[CTRL_CSEL_L +: 2]);

    // Comparator function; unknown codes read as false
    function automatic logic cmp_fn(input tcp_cmp_t f, input logic [CW-1:0] c,
                                    input logic [CW-1:0] v);
        case (f)
            CMP_LT:  cmp_fn = c <  v;
            CMP_LE:  cmp_fn = c <= v;
            CMP_EQ:  cmp_fn = c == v;
            CMP_GE:  cmp_fn = c >= v;
            CMP_GT:  cmp_fn = c >  v;
            default: cmp_fn = 1'b0;
        endcase
    endfunction

    // Write strobe merge for one register word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        for (int i = 0; i < 4; i++)
            merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    endfunction

    // ------------------------------------------------------------------
    // AXI write path: address and data taken in either order
    // ------------------------------------------------------------------
    logic wr_go;
    assign wr_go = aw_ff && w_ff && !S_AXI_BVALID;

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            aw_ff         <= 1'b0;
            w_ff          <= 1'b0;
            awaddr_ff     <= '0;
            wdata_ff      <= '0;
            wstrb_ff      <= '0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= RESP_OKAY;
        end
        else
        begin
            S_AXI_AWREADY <= !aw_ff && !S_AXI_AWREADY && S_AXI_AWVALID;
            S_AXI_WREADY  <= !w_ff && !S_AXI_WREADY && S_AXI_WVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_ff     <= 1'b1;
                awaddr_ff <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_ff     <= 1'b1;
                wdata_ff <= S_AXI_WDATA;
                wstrb_ff <= S_AXI_WSTRB;
            end
            if (wr_go)
            begin
                aw_ff        <= 1'b0;
                w_ff         <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= (awaddr_ff > OFF_CLKDIV || awaddr_ff[1:0] != 2'b00
                                 || awaddr_ff == OFF_COUNT || awaddr_ff == OFF_CAPT
                                 || awaddr_ff == OFF_STAT) ? RESP_SLVERR : RESP_OKAY;
            end
            else if (S_AXI_BVALID && S_AXI_BREADY)
                S_AXI_BVALID <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers written by software
    // ------------------------------------------------------------------
    logic [31:0] ctrl_new;
    assign ctrl_new = merge(ctrl_ff, wdata_ff, wstrb_ff);

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            ctrl_ff   <= '0;
            period_ff <= RST_PERIOD;
            cmp_ff    <= RST_CMP;
            dead_ff   <= RST_DEAD;
            clkdiv_ff <= RST_CLKDIV;
            ien_ff    <= '0;
            start_ff  <= 1'b0;
        end
        else
        begin
            start_ff <= 1'b0;
            if (wr_go)
            begin
                unique case (awaddr_ff)
                    OFF_CTRL:
                    begin
                        ctrl_ff  <= {22'h0, 1'b0, ctrl_new[8:0]};
                        start_ff <= ctrl_new[CTRL_START];
                    end
                    OFF_PERIOD: period_ff <= CW'(merge({16'h0000, period_ff}, wdata_ff, wstrb_ff));
                    OFF_CMP:    cmp_ff    <= CW'(merge({16'h0000, cmp_ff}, wdata_ff, wstrb_ff));
                    OFF_DEAD:   dead_ff   <= 8'(merge({24'h000000, dead_ff}, wdata_ff, wstrb_ff));
                    OFF_IEN:    ien_ff    <= 3'(merge({29'h0, ien_ff}, wdata_ff, wstrb_ff));
                    OFF_CLKDIV: clkdiv_ff <= 16'(merge({16'h0000, clkdiv_ff}, wdata_ff, wstrb_ff));
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Count clock enable: system, divided, or routed edge
    // ------------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            div_cnt_ff  <= '0;
            div_tick_ff <= 1'b0;
        end
        else
        begin
            div_tick_ff <= (div_cnt_ff == '0);
            div_cnt_ff  <= (div_cnt_ff == '0) ? clkdiv_ff : div_cnt_ff - 16'h0001;
        end
    end

    logic cnt_en;
    always_comb
    begin
        unique case (csel)
            CSRC_SYS: cnt_en = 1'b1;
            CSRC_DIV: cnt_en = div_tick_ff;
            CSRC_EXT: cnt_en = ext_rise;
            default:  cnt_en = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Down counter
    // ------------------------------------------------------------------
    logic step;
    logic exhaust;
    assign step    = run && !stop_ff && cnt_en
                     && (mode != MODE_GATE || en_lvl);
    assign exhaust = step && (count_ff == '0);

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            count_ff <= RST_PERIOD;
            stop_ff  <= 1'b0;
        end
        else if (start_ff || rst_rise)
        begin
            count_ff <= period_ff;
            stop_ff  <= 1'b0;
        end
        else if (exhaust)
        begin
            count_ff <= period_ff;
            stop_ff  <= (mode == MODE_ONCE);
        end
        else if (step)
            count_ff <= count_ff - 1'b1;
    end

    // Capture of the live count on a routed edge
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
            capt_ff <= '0;
        else if (cap_rise)
            capt_ff <= count_ff;
    end

    // ------------------------------------------------------------------
    // Outputs; kill forces comparator-driven outputs low
    // ------------------------------------------------------------------
    logic cmp_true;
    assign cmp_true = run && cmp_fn(cmp_sel, count_ff, cmp_ff);

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            CMP_OUT         <= 1'b0;
            COUNT_EXHAUSTED <= 1'b0;
        end
        else
        begin
            CMP_OUT <= cmp_true && !kill_lvl;
            if (ctrl_ff[CTRL_COMP])
                COUNT_EXHAUSTED <= !cmp_true && run && !kill_lvl;
            else
                COUNT_EXHAUSTED <= exhaust;
        end
    end

    logic db_hi;
    logic db_lo;
    tcp_deadband #(.DW(8)) u_db (
        .clk    (CLK),
        .resetn (RESETN),
        .cnt_en (cnt_en),
        .pwm    (cmp_true),
        .dead   (dead_ff),
        .out_hi (db_hi),
        .out_lo (db_lo)
    );

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            PWM_HI <= 1'b0;
            PWM_LO <= 1'b0;
        end
        else
        begin
            PWM_HI <= db_hi && run && !kill_lvl;
            PWM_LO <= db_lo && run && !kill_lvl;
        end
    end

    // ------------------------------------------------------------------
    // Sticky status and interrupt; a new event beats a clear
    // ------------------------------------------------------------------
    logic [2:0] events;
    logic       cmp_d_ff;
    logic [2:0] clr;
    assign events = {cap_rise, cmp_true && !cmp_d_ff, exhaust};
    assign clr    = (wr_go && awaddr_ff == OFF_CLR && wstrb_ff[0]) ? wdata_ff[2:0] : 3'b000;

    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            stat_ff  <= '0;
            cmp_d_ff <= 1'b0;
            IRQ      <= 1'b0;
        end
        else
        begin
            cmp_d_ff <= cmp_true;
            stat_ff  <= (stat_ff & ~clr) | events;
            IRQ      <= |(((stat_ff & ~clr) | events) & ien_ff);
        end
    end

    // ------------------------------------------------------------------
    // AXI read path; live count readable at any time
    // ------------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= '0;
            S_AXI_RRESP   <= RESP_OKAY;
        end
        else
        begin
            S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY)
            begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP  <= RESP_OKAY;
                unique case (S_AXI_ARADDR)
                    OFF_CTRL:   S_AXI_RDATA <= ctrl_ff;
                    OFF_PERIOD: S_AXI_RDATA <= {16'h0000, period_ff};
                    OFF_CMP:    S_AXI_RDATA <= {16'h0000, cmp_ff};
                    OFF_DEAD:   S_AXI_RDATA <= {24'h000000, dead_ff};
                    OFF_COUNT:  S_AXI_RDATA <= {16'h0000, count_ff};
                    OFF_CAPT:   S_AXI_RDATA <= {16'h0000, capt_ff};
                    OFF_STAT:   S_AXI_RDATA <= {29'h0, stat_ff};
                    OFF_CLR:    S_AXI_RDATA <= '0;
                    OFF_IEN:    S_AXI_RDATA <= {29'h0, ien_ff};
                    OFF_CLKDIV: S_AXI_RDATA <= {16'h0000, clkdiv_ff};
                    default:
                    begin
                        S_AXI_RDATA <= '0;
                        S_AXI_RRESP <= RESP_SLVERR;
                    end
                endcase
            end
            else if (S_AXI_RVALID && S_AXI_RREADY)
                S_AXI_RVALID <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### tcp_timer_checker.sv
// Checker for the timer top: bus handshakes and output relations.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module tcp_timer_checker
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic KILL,
    input wire logic CMP_OUT,
    input wire logic COUNT_EXHAUSTED,
    input wire logic PWM_HI,
    input wire logic PWM_LO,
    input wire logic IRQ
);
    // ------------------------------------------------------------
    // Properties, all on CLK and quiet while reset is low
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);
    chk_reset_quiet: assert property (
        $rose(RESETN) |-> !(CMP_OUT || COUNT_EXHAUSTED || PWM_HI || PWM_LO || IRQ))
        else $error("Outputs not quiet after reset");
    chk_pwm_apart: assert property (!(PWM_HI && PWM_LO))
        else $error("Both pulse outputs high together");
    // Sync latency is about three clocks, so five held cycles leave margin
    chk_kill_off: assert property (KILL [*5] |=> !(CMP_OUT || PWM_HI || PWM_LO))
        else $error("Kill did not force outputs low");
    chk_aw_taken: assert property ($rose(S_AXI_AWVALID) |=> S_AXI_AWREADY)
        else $error("Write address not taken one cycle after valid");
    chk_w_taken: assert property ($rose(S_AXI_WVALID) |=> S_AXI_WREADY)
        else $error("Write data not taken one cycle after valid");
    chk_b_follows: assert property (S_AXI_AWVALID && S_AXI_AWREADY |-> ##[1:3] S_AXI_BVALID)
        else $error("Write response late");
    chk_ar_taken: assert property ($rose(S_AXI_ARVALID) |=> S_AXI_ARREADY)
        else $error("Read address not taken one cycle after valid");
    chk_r_follows: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("Read data not valid after address");
    chk_r_drops: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
        else $error("Read data kept valid after it was taken");
endmodule
`default_nettype wire
